// ### logic/tes_lut_mem.sv
// Purpose: edge lookup table memory, one write port, registered read
// Assumes: write and read on the same edge to one word returns old data
// Notes: four tables of 32 amplitude fractions each by default
module tes_lut_mem #(
   parameter int AW = 7,
   parameter int DEPTH = 128
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [7:0] rd_data
);
   typedef struct packed {
      logic [DEPTH-1:0][7:0] mem;
      logic [7:0] rdata;
   } tes_lut_s;

   tes_lut_s s;
   tes_lut_s nx;

   // ------------------------------------------------------------
   // write and read
   // ------------------------------------------------------------
   always_comb begin
      nx = s;
      if (wr_en) begin
         nx.mem[wr_addr] = wr_data;
      end
      nx.rdata = s.mem[rd_addr]; // old word on collision
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= nx;
      end
   end

   assign rd_data = s.rdata;

endmodule : tes_lut_mem

// ### logic/tes_params.svh
// Purpose: constants for the transmitter edge shaping block
// Assumes: included by the package, the shaper and the bench
// Notes: register indices are word indices; byte address = 4 * index
`ifndef TES_PARAMS_SVH
`define TES_PARAMS_SVH

// ---------------------------------------------------------------
// register indices
// ---------------------------------------------------------------
`define TES_IDX_RES_LONG 8'h5C
`define TES_IDX_KIND_LONG 8'h5D
`define TES_IDX_STYLE_LONG 8'h5E
`define TES_IDX_LEN_LONG 8'h5F
`define TES_IDX_RES_SHORT 8'h60
`define TES_IDX_KIND_SHORT 8'h61
`define TES_IDX_STYLE_SHORT 8'h62
`define TES_IDX_LEN_SHORT 8'h63
`define TES_IDX_CTRL 8'h70
`define TES_IDX_STATUS 8'h71
`define TES_LUT_BIT 7
`define TES_IDX_LSB 2
`define TES_IDX_MSB 9

// ---------------------------------------------------------------
// fields, masks and reset values
// ---------------------------------------------------------------
`define TES_MASK_STYLE 8'h77
`define TES_MASK_LEN 8'h9F
`define TES_KIND_FALL 7:4
`define TES_KIND_RISE 3:0
`define TES_STYLE_FALL 6:4
`define TES_STYLE_RISE 2:0
`define TES_LEN_STRETCH 7
`define TES_LEN_COUNT 4:0
`define TES_CTRL_EN 0
`define TES_CTRL_LONG 1
`define TES_STAT_BUSY 0
`define TES_STAT_FAULT 1
`define TES_STAT_MOD 2
`define TES_STAT_AMP 15:8
`define TES_RST_RES 8'h00
`define TES_RST_KIND 8'h11
`define TES_RST_STYLE 8'h00
`define TES_RST_LEN 8'h04

// ---------------------------------------------------------------
// edge style codes and amplitude constants
// ---------------------------------------------------------------
`define TES_CODE_FW1 4'h1
`define TES_CODE_FW2 4'h2
`define TES_CODE_FW3 4'h3
`define TES_CODE_LUT 4'h4
`define TES_CODE_LUT_CORR 4'h5
`define TES_CODE_LUT_NOCORR 4'h6
`define TES_FULL 8'hFF
`define TES_HALF 8'h80
`define TES_SPAN_HIGH 8'h7F
`define TES_KNEE_LOW 5'h10
`define TES_PA_NOM 8'h80
`define TES_HTRANS_ACT 1
`define TES_HRESP_OKAY 1'b0

`endif

// ### logic/tes_pkg.sv
// Purpose: types of the transmitter edge shaping block
// Assumes: tes_params.svh on the include path
// Notes: all state of the top module except the table memory lives in tes_state_s
package tes_pkg;
`include "tes_params.svh"

   // ------------------------------------------------------------
   // shaper sequencer states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      TES_IDLE = 3'b001,
      TES_RAMP = 3'b010,
      TES_CORR = 3'b100
   } tes_fsm_e;

   // ------------------------------------------------------------
   // whole state of the shaper and its bus slave
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] res_long;
      logic [7:0] kind_long;
      logic [7:0] style_long;
      logic [7:0] len_long;
      logic [7:0] res_short;
      logic [7:0] kind_short;
      logic [7:0] style_short;
      logic [7:0] len_short;
      logic en;
      logic tari_long;
      logic fault;
      logic dp_wr;
      logic [7:0] dp_idx;
      logic [31:0] rdata;
      logic ready;
      logic resp;
      tes_fsm_e st;
      logic [3:0] code;
      logic [2:0] cfg;
      logic [4:0] n;
      logic stretch;
      logic [5:0] step;
      logic hold;
      logic [7:0] from;
      logic [7:0] to;
      logic mod_applied;
      logic [7:0] amp;
      logic busy;
   } tes_state_s;

endpackage : tes_pkg

// ### logic/tes_shaper.sv
// Purpose: edge shaping of the carrier amplitude for two Tari settings
// Assumes: carrier_tick pulses one hclk per carrier cycle, >= 2 apart
// Notes: registers reached over AHB-Lite, zero wait states
//
// Operation
// - firmware falling codes use style bits 6:4 as time constant.
// - table falling codes use style bits 5:4 as table index.
// - firmware rising codes use style bits 2:0 as time constant.
// - table rising codes use style bits 1:0 as table index.
// - length bit 7 clear holds each state one carrier cycle.
// - length bit 7 set holds each state two carrier cycles.
// - length bits 4:0 give state count for both edges.
// - residual byte scales amplitude linearly, 0x00 none, 0xFF full.
// - falling codes 1, 2, 3 give one, two, three linear segments.
// - code 4 uses table with no supply adaptation.
// - code 5 uses table, supply adaptation and a correction state.
// - code 6 uses table, supply adaptation, no correction state.
// - rising code in bits 3:0, same encoding, independent edge.
// - sets apply in mode 3 reader transmit; one set per Tari.
`include "tes_params.svh"
module tes_shaper #(
   parameter int ADDR_W = 12,
   parameter logic [7:0] PA_NOMINAL = `TES_PA_NOM
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic tx_mod,
   input wire logic carrier_tick,
   input wire logic [7:0] pa_supply_voltage,
   output logic [7:0] amplitude,
   output logic edge_busy
);
   import tes_pkg::*;

   tes_state_s s;
   tes_state_s nx;
   logic [7:0] idx;
   logic [31:0] rd;
   logic lut_we;
   logic [6:0] lut_rd_addr;
   logic [7:0] lut_rdata;
   logic [7:0] sel_res;
   logic [7:0] sel_kind;
   logic [7:0] sel_style;
   logic [7:0] sel_len;
   logic [7:0] target;
   logic [3:0] code_new;
   logic [2:0] cfg_new;
   logic [7:0] t;
   logic [7:0] f;
   logic [7:0] val;

   // ------------------------------------------------------------
   // arithmetic helpers
   // ------------------------------------------------------------

   // position of state k of n as a fraction of 255
   function automatic logic [7:0] lin_frac(input logic [5:0] k, input logic [4:0] n);
      logic [13:0] p;
      p = 14'(k) * 14'(`TES_FULL);
      lin_frac = 8'(p / 14'(n));
   endfunction : lin_frac

   // two segments meeting at half time, knee level set by tc
   function automatic logic [7:0] knee_map(input logic [7:0] tin, input logic [2:0] tc);
      logic [7:0] knee;
      logic [15:0] p;
      knee = {tc, `TES_KNEE_LOW};
      if (tin < `TES_HALF) begin
         p = 16'(tin) * 16'(knee);
         knee_map = p[14:7];
      end else begin
         p = (16'(tin - `TES_HALF) * 16'(`TES_FULL - knee)) / 16'(`TES_SPAN_HIGH);
         knee_map = knee + p[7:0]; // upper segment ends exactly at full
      end
   endfunction : knee_map

   // firmware segment shaping
   function automatic logic [7:0] fw_frac(input logic [3:0] c, input logic [7:0] tin,
                                          input logic [2:0] tc);
      case (c)
         `TES_CODE_FW2: fw_frac = knee_map(tin, tc);
         `TES_CODE_FW3: fw_frac = knee_map(knee_map(tin, tc), tc);
         default: fw_frac = tin;
      endcase
   endfunction : fw_frac

   // scale table fraction by nominal over actual supply
   function automatic logic [7:0] adapt(input logic [7:0] fin, input logic [7:0] vdd,
                                        input logic [7:0] nom);
      logic [15:0] q;
      if (vdd == 8'h00) begin
         adapt = fin;
      end else begin
         q = (16'(fin) * 16'(nom)) / 16'(vdd);
         adapt = (q > 16'(`TES_FULL)) ? `TES_FULL : q[7:0];
      end
   endfunction : adapt

   // linear blend between two amplitude bytes
   function automatic logic [7:0] mix(input logic [7:0] a, input logic [7:0] b,
                                      input logic [7:0] fin);
      logic [16:0] acc;
      acc = 17'(16'(a) * 16'(`TES_FULL - fin)) + 17'(16'(b) * 16'(fin)) + 17'(8'h7F);
      mix = 8'(acc / 17'(`TES_FULL));
   endfunction : mix

   // style codes that start a shaped edge
   function automatic logic code_ok(input logic [3:0] c);
      code_ok = (c >= `TES_CODE_FW1) && (c <= `TES_CODE_LUT_NOCORR);
   endfunction : code_ok

   // ------------------------------------------------------------
   // lookup table memory
   // ------------------------------------------------------------
   tes_lut_mem #(
      .AW(7),
      .DEPTH(128)
   ) u_lut (
      .hclk(hclk),
      .hresetn(hresetn),
      .wr_en(lut_we),
      .wr_addr(s.dp_idx[6:0]),
      .wr_data(hwdata[7:0]),
      .rd_addr(lut_rd_addr),
      .rd_data(lut_rdata)
   );

   // ------------------------------------------------------------
   // set selection and per-state amplitude
   // ------------------------------------------------------------
   always_comb begin
      sel_res = s.tari_long ? s.res_long : s.res_short;
      sel_kind = s.tari_long ? s.kind_long : s.kind_short;
      sel_style = s.tari_long ? s.style_long : s.style_short;
      sel_len = s.tari_long ? s.len_long : s.len_short;
      target = tx_mod ? sel_res : `TES_FULL;
      code_new = tx_mod ? sel_kind[`TES_KIND_FALL] : sel_kind[`TES_KIND_RISE];
      cfg_new = tx_mod ? sel_style[`TES_STYLE_FALL] : sel_style[`TES_STYLE_RISE];
      t = lin_frac(s.step, s.n);
      if (s.code >= `TES_CODE_LUT) begin
         f = lut_rdata;
         if (s.code != `TES_CODE_LUT) begin
            f = adapt(lut_rdata, pa_supply_voltage, PA_NOMINAL);
         end
      end else begin
         f = fw_frac(s.code, t, s.cfg);
      end
      val = mix(s.from, s.to, f);
   end

   // ------------------------------------------------------------
   // next state: bus writes, shaper, bus reads
   // ------------------------------------------------------------
   always_comb begin
      nx = s;
      lut_we = 1'b0;
      idx = haddr[`TES_IDX_MSB:`TES_IDX_LSB];
      rd = 32'h0000_0000;
      // data phase of a write
      if (s.dp_wr) begin
         nx.dp_wr = 1'b0;
         if (s.dp_idx[`TES_LUT_BIT]) begin
            lut_we = 1'b1;
         end else begin
            case (s.dp_idx)
               `TES_IDX_RES_LONG: nx.res_long = hwdata[7:0];
               `TES_IDX_KIND_LONG: nx.kind_long = hwdata[7:0];
               `TES_IDX_STYLE_LONG: nx.style_long = hwdata[7:0] & `TES_MASK_STYLE;
               `TES_IDX_LEN_LONG: nx.len_long = hwdata[7:0] & `TES_MASK_LEN;
               `TES_IDX_RES_SHORT: nx.res_short = hwdata[7:0];
               `TES_IDX_KIND_SHORT: nx.kind_short = hwdata[7:0];
               `TES_IDX_STYLE_SHORT: nx.style_short = hwdata[7:0] & `TES_MASK_STYLE;
               `TES_IDX_LEN_SHORT: nx.len_short = hwdata[7:0] & `TES_MASK_LEN;
               `TES_IDX_CTRL: begin
                  nx.en = hwdata[`TES_CTRL_EN];
                  nx.tari_long = hwdata[`TES_CTRL_LONG];
               end
               `TES_IDX_STATUS: begin
                  if (hwdata[`TES_STAT_FAULT]) begin
                     nx.fault = 1'b0; // write one clears
                  end
               end
               default: begin
               end
            endcase
         end
      end
      // shaper sequencer; a new fault below overrides the clear above
      if (!s.en) begin
         nx.st = TES_IDLE;
         nx.amp = target;
         nx.mod_applied = tx_mod;
         nx.hold = 1'b0;
      end else begin
         case (s.st)
            TES_IDLE: begin
               if (tx_mod != s.mod_applied) begin
                  nx.mod_applied = tx_mod;
                  if (!code_ok(code_new)) begin
                     nx.amp = target;
                     nx.fault = 1'b1;
                  end else if (sel_len[`TES_LEN_COUNT] == 5'h00) begin
                     nx.amp = target;
                  end else begin
                     nx.st = TES_RAMP;
                     nx.code = code_new;
                     nx.cfg = cfg_new;
                     nx.n = sel_len[`TES_LEN_COUNT];
                     nx.stretch = sel_len[`TES_LEN_STRETCH];
                     nx.step = 6'h01;
                     nx.hold = 1'b0;
                     nx.from = s.amp;
                     nx.to = target;
                  end
               end
            end
            TES_RAMP: begin
               if (carrier_tick) begin
                  if (s.hold) begin
                     nx.hold = 1'b0;
                  end else if (s.step <= 6'(s.n)) begin
                     nx.amp = val;
                     nx.step = s.step + 6'h01;
                     nx.hold = s.stretch;
                  end else if (s.code == `TES_CODE_LUT_CORR) begin
                     nx.amp = s.to;
                     nx.hold = s.stretch;
                     nx.st = TES_CORR;
                  end else begin
                     nx.st = TES_IDLE;
                  end
               end
            end
            TES_CORR: begin
               if (carrier_tick) begin
                  if (s.hold) begin
                     nx.hold = 1'b0;
                  end else begin
                     nx.st = TES_IDLE;
                  end
               end
            end
            default: begin
               nx.st = TES_IDLE;
            end
         endcase
      end
      nx.busy = (nx.st != TES_IDLE);
      // address phase; reads see this cycle's write
      if (hsel && hready && htrans[`TES_HTRANS_ACT]) begin
         nx.dp_wr = hwrite;
         nx.dp_idx = idx;
         if (!hwrite) begin
            case (idx)
               `TES_IDX_RES_LONG: rd[7:0] = nx.res_long;
               `TES_IDX_KIND_LONG: rd[7:0] = nx.kind_long;
               `TES_IDX_STYLE_LONG: rd[7:0] = nx.style_long;
               `TES_IDX_LEN_LONG: rd[7:0] = nx.len_long;
               `TES_IDX_RES_SHORT: rd[7:0] = nx.res_short;
               `TES_IDX_KIND_SHORT: rd[7:0] = nx.kind_short;
               `TES_IDX_STYLE_SHORT: rd[7:0] = nx.style_short;
               `TES_IDX_LEN_SHORT: rd[7:0] = nx.len_short;
               `TES_IDX_CTRL: begin
                  rd[`TES_CTRL_EN] = nx.en;
                  rd[`TES_CTRL_LONG] = nx.tari_long;
               end
               `TES_IDX_STATUS: begin
                  rd[`TES_STAT_BUSY] = nx.busy;
                  rd[`TES_STAT_FAULT] = nx.fault;
                  rd[`TES_STAT_MOD] = nx.mod_applied;
                  rd[`TES_STAT_AMP] = nx.amp;
               end
               default: rd = 32'h0000_0000; // unmapped and table reads
            endcase
            nx.rdata = rd;
         end
      end
      nx.ready = 1'b1;
      nx.resp = `TES_HRESP_OKAY;
   end

   // table address follows the step being entered
   assign lut_rd_addr = {nx.cfg[1:0], 5'(nx.step - 6'h01)};

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
         s.res_long <= `TES_RST_RES;
         s.kind_long <= `TES_RST_KIND;
         s.style_long <= `TES_RST_STYLE;
         s.len_long <= `TES_RST_LEN;
         s.res_short <= `TES_RST_RES;
         s.kind_short <= `TES_RST_KIND;
         s.style_short <= `TES_RST_STYLE;
         s.len_short <= `TES_RST_LEN;
         s.ready <= 1'b1;
         s.st <= TES_IDLE;
         s.step <= 6'h01;
         s.amp <= `TES_FULL;
      end else begin
         s <= nx;
      end
   end

   // outputs straight from flip-flops
   assign hrdata = s.rdata;
   assign hreadyout = s.ready;
   assign hresp = s.resp;
   assign amplitude = s.amp;
   assign edge_busy = s.busy;

endmodule : tes_shaper

// ### test/tb_top.sv
// Purpose: self-checking bench for the edge shaping block
// Assumes: zero wait state slave, carrier ticks 2 or more clocks apart
// Notes: byte address is four times the word index
`include "tes_params.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------
   // signals and model state
   // ----------------
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic tx_mod = 1'b0, carrier_tick = 1'b0, hready, hreadyout, hresp, edge_busy;
   logic [11:0] haddr = 12'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0, hrdata, rd;
   logic [7:0] pa_supply_voltage = 8'h0, amplitude, kind, sty, len, res;
   logic en = 1'b0, lng = 1'b0;
   int err_count = 0, num_checks = 0, cyc = 0, cur = 255, fault_m = 0, lut_m[128];

   // single slave, clock of 8 ns
   assign hready = hreadyout;
   always #4 hclk = ~hclk;

   tes_shaper uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hrdata, .hreadyout, .hresp, .tx_mod, .carrier_tick, .pa_supply_voltage,
      .amplitude, .edge_busy);

   // ----------------
   // helpers
   // ----------------
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : stop_test

   task automatic chk(logic [31:0] got, logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
         err_count++;
      end
   endtask : chk

   // one single word transfer, waits on hready
   task automatic bus(logic w, int idx, logic [31:0] wd, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= 12'(idx * 4);
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : bus

   task automatic wr(int idx, logic [31:0] d);
      bus(1'b1, idx, d, rd);
   endtask : wr

   task automatic rdc(int idx, logic [31:0] e);
      bus(1'b0, idx, 32'h0, rd);
      chk(rd, e);
   endtask : rdc

   // one carrier cycle; returns just after the update edge
   task automatic tick();
      @(posedge hclk);
      carrier_tick <= 1'b1;
      @(posedge hclk);
      carrier_tick <= 1'b0;
      #1;
   endtask : tick

   // blend rounded to nearest
   function automatic int mix(int f, int fr, int to);
      return (fr * (255 - f) + to * f + 127) / 255;
   endfunction : mix

   // two segments, knee level tc * 32 + 16 at half time
   function automatic int knee(int t, int tc);
      int kn;
      kn = tc * 32 + 16;
      if (t < 128)
         return t * kn / 128;
      return kn + (t - 128) * (255 - kn) / 127;
   endfunction : knee

   // program the chosen set and control
   task automatic cfg();
      int b;
      b = lng ? `TES_IDX_RES_LONG : `TES_IDX_RES_SHORT;
      wr(b, res);
      wr(b + 1, kind);
      wr(b + 2, sty);
      wr(b + 3, len);
      wr(`TES_IDX_CTRL, {lng, en});
      rdc(b + 3, len);
   endtask : cfg

   // one edge, modelled state by state
   task automatic shape(bit fall);
      int c, tc, n, st, to, fr, f;
      c = fall ? kind[7:4] : kind[3:0];
      tc = fall ? sty[6:4] : sty[2:0];
      n = len[4:0];
      st = len[7] ? 2 : 1;
      to = fall ? res : 255;
      fr = cur;
      @(posedge hclk);
      tx_mod <= fall;
      @(posedge hclk);
      #1;
      if (c < 1 || c > 6 || n == 0 || !en) begin
         fault_m = en && (c < 1 || c > 6);
         cur = to;
         chk(amplitude, to);
         chk(edge_busy, 1'b0);
      end else begin
         chk(edge_busy, 1'b1);
         for (int k = 1; k <= n; k++) begin
            f = k * 255 / n;
            if (c == 2)
               f = knee(f, tc);
            else if (c == 3)
               f = knee(knee(f, tc), tc);
            else if (c > 3)
               f = lut_m[tc % 4 * 32 + k - 1];
            if (c > 4 && pa_supply_voltage != 8'h0)
               f = f * `TES_PA_NOM / pa_supply_voltage;
            cur = mix(f > 255 ? 255 : f, fr, to);
            repeat (st) tick();
            chk(amplitude, cur);
         end
         if (c == 5) begin
            cur = to;
            repeat (st) tick();
            chk(amplitude, to);
         end
         repeat (st) tick();
         chk(edge_busy, 1'b0);
      end
      bus(1'b0, `TES_IDX_STATUS, 32'h0, rd);
      chk(rd, {16'h0, 8'(cur), 5'h0, fall, fault_m[0], 1'b0});
      wr(`TES_IDX_STATUS, 32'h2);
      fault_m = 0;
   endtask : shape

   // hang guard
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         stop_test();
      end
   end

   // ----------------
   // tests
   // ----------------
   initial begin
      int i, fc;
      logic [7:0] rv[4], mk[4];
      rv = '{`TES_RST_RES, `TES_RST_KIND, `TES_RST_STYLE, `TES_RST_LEN};
      mk = '{8'hFF, 8'hFF, `TES_MASK_STYLE, `TES_MASK_LEN};
      void'($urandom(32'h3AC0));
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(`TES_IDX_STATUS, 32'hFF00);
      rdc(`TES_IDX_CTRL, 32'h0);
      for (i = 0; i < 8; i++) begin
         rdc(`TES_IDX_RES_LONG + i, rv[i % 4]);
         wr(`TES_IDX_RES_LONG + i, 32'hFFFF_FFFF);
         rdc(`TES_IDX_RES_LONG + i, mk[i % 4]);
      end
      wr(8'h40, 32'h5A);
      rdc(8'h40, 32'h0);
      rdc(8'h80, 32'h0);
      $display("register test done");
      for (i = 0; i < 128; i++) begin
         lut_m[i] = $urandom_range(255);
         wr(128 + i, lut_m[i]);
      end
      en = 1'b1;
      for (i = 0; i < 12; i++) begin
         fc = i % 6 + 1;
         kind = 8'(fc * 16 + (i + 1) % 6 + 1);
         sty = 8'($urandom) & `TES_MASK_STYLE;
         len = 8'($urandom_range(6, 1)) | (i > 5 ? 8'h80 : 8'h0);
         res = i < 2 ? 8'(i * 255) : 8'($urandom);
         lng = i[0];
         @(posedge hclk);
         pa_supply_voltage <= i == 4 ? 8'h0 : 8'($urandom_range(255, 64));
         cfg();
         shape(1'b1);
         shape(1'b0);
      end
      $display("shaping codes test done");
      // reserved codes, zero count, then disabled
      kind = 8'h70;
      len = 8'h04;
      cfg();
      shape(1'b1);
      shape(1'b0);
      kind = 8'h11;
      len = 8'h0;
      cfg();
      shape(1'b1);
      shape(1'b0);
      en = 1'b0;
      len = 8'h04;
      cfg();
      shape(1'b1);
      shape(1'b0);
      $display("immediate switch test done");
      stop_test();
   end
endmodule : tb_top

bind tes_shaper tes_shaper_sva u_sva (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
   .hrdata, .hreadyout, .hresp, .tx_mod, .carrier_tick, .amplitude, .edge_busy);

// ### test/tes_shaper_sva.sv
// Purpose: port checker for the edge shaping block
// Assumes: one clock domain, active-low reset
// Notes: bound to tes_shaper from tb_top
module tes_shaper_sva (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic tx_mod,
   input wire logic carrier_tick,
   input wire logic [7:0] amplitude,
   input wire logic edge_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------
   // bus slave
   // ----------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // zero wait states, okay only, idle values after reset
   a_ready_high: assert property (hreadyout)
      else $error("hreadyout dropped");
   a_resp_okay: assert property (!hresp)
      else $error("hresp not okay");
   a_reset_values: assert property ($rose(hresetn) |-> amplitude == 8'hFF && !edge_busy
      && hrdata == 32'h0) else $error("bad values after reset");
   a_upper_zero: assert property (hrdata[31:16] == 16'h0)
      else $error("read data upper half set");
   a_rdata_hold: assert property (!$past(hsel && hready && htrans[1] && !hwrite)
      |-> $stable(hrdata)) else $error("read data moved without a read");

   // ----------------
   // shaper
   // ----------------
   a_busy_start: assert property ($rose(edge_busy) |-> $past(tx_mod) != $past(tx_mod, 2))
      else $error("edge started without a request change");
   a_amp_on_tick: assert property ($past(edge_busy) && $changed(amplitude)
      |-> $past(carrier_tick)) else $error("amplitude moved between carrier cycles");
   a_busy_bound: assert property ($rose(edge_busy) |-> ##[1:1000] !edge_busy)
      else $error("edge sequence never ended");
endmodule : tes_shaper_sva
